//--- shared/cmad_defines.svh
// Address map and field constants for the core memory address decoder
`ifndef CMAD_DEFINES_SVH
`define CMAD_DEFINES_SVH
// ==========================================
// Address widths
`define CMAD_PROG_ADDR_W 21
`define CMAD_DATA_ADDR_W 22
`define CMAD_EXT_W 24
// ==========================================
// Program map: byte boundary and internal size in words; data map: internal select bit and size in bytes
`define CMAD_PROG_BOUNDARY_BYTE 22'h3FBFFF
`define CMAD_PROG_INT_WORDS 14'h2000
`define CMAD_DATA_INT_BIT 21
`define CMAD_DATA_INT_BYTES 22'h012000
// ==========================================
// Coprocessor internal memory sizes in words
`define CMAD_X_WORDS 15'h4000
`define CMAD_Y_WORDS 15'h2000
`define CMAD_COP_W 16
// ==========================================
// External map
`define CMAD_EXT_SDRAM_BIT 23
`define CMAD_SRAM_MIN_SEL 2'h0
`define CMAD_SRAM_MAX_SEL 2'h3
`endif

//--- shared/cmad_pkg.sv
// Types shared by the core memory address decoder
package cmad_pkg;
   typedef enum logic [1:0] {
      CMAD_TGT_INT = 2'h0,
      CMAD_TGT_CACHE = 2'h1,
      CMAD_TGT_NONE = 2'h3
   } cmad_target_t;
   typedef struct packed {
      logic valid;
      logic [20:0] addr;
   } cmad_prog_req_t;
   typedef struct packed {
      logic valid;
      logic [21:0] addr;
   } cmad_data_req_t;
   typedef struct packed {
      logic valid;
      logic ymem;
      logic [15:0] addr;
   } cmad_cop_req_t;
   typedef struct packed {
      logic valid;
      logic sdram;
      logic [23:0] addr;
   } cmad_ext_req_t;
   typedef enum logic [1:0] {
      CMAD_IRQ_IDLE = 2'b00,
      CMAD_IRQ_PEND = 2'b01
   } cmad_irq_state_t;
endpackage : cmad_pkg

//--- design/cmad_ext_map.sv
// External address former: base pointer above request offset, SRAM or SDRAM half
`timescale 1ns/10ps
`include "cmad_defines.svh"
module cmad_ext_map (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // Request
   input wire logic req_valid,
   input wire logic [20:0] req_offset,
   input wire logic [23:0] base_pointer,
   input wire logic [1:0] sram_size_sel,
   // Result
   output cmad_pkg::cmad_ext_req_t ext_req
);
   logic [23:0] offset_mask;
   logic [23:0] next_addr;
   logic [23:0] sram_mask;
   always_comb begin
      // SRAM bank of 256K words shifted up by size select, up to 2M words
      sram_mask = (24'h03FFFF << sram_size_sel) | 24'h03FFFF;
      offset_mask = 24'h03FFFF;
      next_addr = (base_pointer & ~offset_mask) | ({3'h0, req_offset} & offset_mask);
      if (!next_addr[`CMAD_EXT_SDRAM_BIT]) begin
         next_addr = next_addr & sram_mask; // R16
      end
   end
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ext_req <= '0;
      end else begin
         ext_req.valid <= req_valid;
         ext_req.addr <= next_addr; // R18
         ext_req.sdram <= next_addr[`CMAD_EXT_SDRAM_BIT]; // R15
      end
   end
endmodule : cmad_ext_map

//--- design/cmad_irq_hold.sv
// Fast interrupt request holder: violations before the take share one request, held until taken
`timescale 1ns/10ps
module cmad_irq_hold (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // Events
   input wire logic violation,
   input wire logic irq_enable,
   input wire logic irq_taken,
   // Request
   output logic irq_req
);
   cmad_pkg::cmad_irq_state_t state;
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         state <= cmad_pkg::CMAD_IRQ_IDLE;
      end else begin
         unique case (state)
            cmad_pkg::CMAD_IRQ_IDLE: begin
               if (violation && irq_enable) begin
                  state <= cmad_pkg::CMAD_IRQ_PEND; // R6 R17
               end
            end
            cmad_pkg::CMAD_IRQ_PEND: begin
               // A new violation in the take cycle keeps the request up only while the enable is set
               if (irq_taken && !(violation && irq_enable)) begin
                  state <= cmad_pkg::CMAD_IRQ_IDLE; // R19
               end
            end
            default: state <= cmad_pkg::CMAD_IRQ_IDLE;
         endcase
      end
   end
   assign irq_req = (state == cmad_pkg::CMAD_IRQ_PEND);
endmodule : cmad_irq_hold

//--- design/cmad_decoder.sv
// Core memory address decoder: program, data and coprocessor routing
// Function
// R1 - Fetch above 3FBFFFH served by internal memory
// R2 - Fetch below 3FC000H goes to instruction cache
// R3 - Data address top bit one: internal
// R4 - Data address top bit zero: data cache
// R5 - Coprocessor bad area raises fast interrupt
// R6 - Violation serviced only when enable bit set
// R7 - Host bad area also raises fast interrupt
// R8 - Program space 21-bit word address
// R9 - Data space 22-bit byte address
// R10 - Internal program memory 8K words
// R11 - Internal data memory 72K bytes
// R12 - Coprocessor X 16K, Y 8K words
// R13 - Off-chip fetch uses instruction base pointer
// R14 - Off-chip data uses data base pointer
// R15 - External 16M: lower SRAM, upper SDRAM
// R16 - SRAM bank 256K to 2M words
// R17 - Fast interrupt only while enable set; a pending request stays up after the enable bit clears, until taken
// R18 - Base pointer above request offset
// R19 - Request held until taken, once each
`timescale 1ns/10ps
`include "cmad_defines.svh"
module cmad_decoder (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // Host program fetch
   input cmad_pkg::cmad_prog_req_t PROG_REQ,
   // Host data access
   input cmad_pkg::cmad_data_req_t DATA_REQ,
   // Coprocessor data access
   input cmad_pkg::cmad_cop_req_t COP_REQ,
   // Core status and base pointers
   input wire logic FAST_IRQ_ENABLE_BIT,
   input wire logic FAST_IRQ_TAKEN,
   input wire logic [23:0] INSTR_CACHE_BASE_POINTER,
   input wire logic [23:0] DATA_CACHE_BASE_POINTER,
   input wire logic [1:0] SRAM_SIZE_SEL,
   // Program routing
   output logic PROG_INT_SEL,
   output logic PROG_CACHE_SEL,
   output logic [12:0] PROG_INT_ADDR,
   // Data routing
   output logic DATA_INT_SEL,
   output logic DATA_CACHE_SEL,
   output logic [16:0] DATA_INT_ADDR,
   // Coprocessor routing
   output logic COP_X_SEL,
   output logic COP_Y_SEL,
   output logic [13:0] COP_INT_ADDR,
   // External addresses
   output cmad_pkg::cmad_ext_req_t PROG_EXT_REQ,
   output cmad_pkg::cmad_ext_req_t DATA_EXT_REQ,
   // Fast interrupt
   output logic FAST_INTERRUPT_REQUEST
);
   // ==========================================
   // Program side
   logic [21:0] prog_byte_addr;
   logic prog_is_int;
   logic prog_cache_go;
   always_comb begin
      prog_byte_addr = {PROG_REQ.addr, 1'b0}; // R8
      prog_is_int = (prog_byte_addr > `CMAD_PROG_BOUNDARY_BYTE); // R1 R2 R10
      prog_cache_go = PROG_REQ.valid && !prog_is_int;
   end
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         PROG_INT_SEL <= 1'b0;
         PROG_CACHE_SEL <= 1'b0;
         PROG_INT_ADDR <= 13'h0000;
      end else begin
         PROG_INT_SEL <= PROG_REQ.valid && prog_is_int; // R1
         PROG_CACHE_SEL <= prog_cache_go; // R2
         PROG_INT_ADDR <= PROG_REQ.addr[12:0]; // R10
      end
   end
   // ==========================================
   // Host data side
   logic [20:0] data_off;
   logic data_int;
   logic data_hole;
   always_comb begin
      data_off = DATA_REQ.addr[20:0]; // R9
      data_int = DATA_REQ.addr[`CMAD_DATA_INT_BIT]; // R3 R4
      data_hole = DATA_REQ.valid && data_int
         && ({1'b0, data_off} >= `CMAD_DATA_INT_BYTES); // R11
   end
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         DATA_INT_SEL <= 1'b0;
         DATA_CACHE_SEL <= 1'b0;
         DATA_INT_ADDR <= 17'h00000;
      end else begin
         DATA_INT_SEL <= DATA_REQ.valid && data_int && !data_hole; // R3
         DATA_CACHE_SEL <= DATA_REQ.valid && !data_int; // R4
         DATA_INT_ADDR <= data_off[16:0];
      end
   end
   // ==========================================
   // Coprocessor side
   logic cop_limit_ok;
   logic cop_hole;
   always_comb begin
      if (COP_REQ.ymem) begin
         cop_limit_ok = ({1'b0, COP_REQ.addr[13:0]} < `CMAD_Y_WORDS); // R12
      end else begin
         cop_limit_ok = ({1'b0, COP_REQ.addr[13:0]} < `CMAD_X_WORDS); // R12
      end
      cop_limit_ok = cop_limit_ok && (COP_REQ.addr[15:14] == 2'h0);
      cop_hole = COP_REQ.valid && !cop_limit_ok; // R5
   end
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         COP_X_SEL <= 1'b0;
         COP_Y_SEL <= 1'b0;
         COP_INT_ADDR <= 14'h0000;
      end else begin
         COP_X_SEL <= COP_REQ.valid && cop_limit_ok && !COP_REQ.ymem; // R5
         COP_Y_SEL <= COP_REQ.valid && cop_limit_ok && COP_REQ.ymem; // R5
         COP_INT_ADDR <= COP_REQ.addr[13:0];
      end
   end
   // ==========================================
   // Violation interrupt
   logic violation;
   assign violation = cop_hole || data_hole; // R5 R7
   cmad_irq_hold u_irq (
      .CLK(CLK),
      .RST_N(RST_N),
      .violation(violation),
      .irq_enable(FAST_IRQ_ENABLE_BIT), // R6 R17
      .irq_taken(FAST_IRQ_TAKEN),
      .irq_req(FAST_INTERRUPT_REQUEST)
   );
   // ==========================================
   // External address forming
   cmad_ext_map u_prog_ext (
      .CLK(CLK),
      .RST_N(RST_N),
      .req_valid(prog_cache_go),
      .req_offset(PROG_REQ.addr),
      .base_pointer(INSTR_CACHE_BASE_POINTER), // R13
      .sram_size_sel(SRAM_SIZE_SEL),
      .ext_req(PROG_EXT_REQ)
   );
   cmad_ext_map u_data_ext (
      .CLK(CLK),
      .RST_N(RST_N),
      .req_valid(DATA_REQ.valid && !data_int),
      .req_offset(data_off),
      .base_pointer(DATA_CACHE_BASE_POINTER), // R14
      .sram_size_sel(SRAM_SIZE_SEL),
      .ext_req(DATA_EXT_REQ)
   );
endmodule : cmad_decoder

//--- testbench/cmad_decoder_assertions.sv
// Port-level checks for the core memory address decoder
`timescale 1ns/10ps
module cmad_decoder_checker (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // Inputs
   input cmad_pkg::cmad_prog_req_t PROG_REQ,
   input cmad_pkg::cmad_data_req_t DATA_REQ,
   input cmad_pkg::cmad_cop_req_t COP_REQ,
   input wire logic FAST_IRQ_ENABLE_BIT,
   input wire logic FAST_IRQ_TAKEN,
   input wire logic [23:0] INSTR_CACHE_BASE_POINTER,
   // Outputs
   input wire logic PROG_INT_SEL,
   input wire logic PROG_CACHE_SEL,
   input wire logic [12:0] PROG_INT_ADDR,
   input wire logic DATA_INT_SEL,
   input wire logic COP_X_SEL,
   input cmad_pkg::cmad_ext_req_t PROG_EXT_REQ,
   input wire logic FAST_INTERRUPT_REQUEST
);
   logic p_hi, flt;
   assign p_hi = PROG_REQ.valid && PROG_REQ.addr >= 21'h1FE000;
   assign flt = FAST_IRQ_ENABLE_BIT && (DATA_REQ.valid && DATA_REQ.addr >= 22'h212000
      || COP_REQ.valid && COP_REQ.addr >= (COP_REQ.ymem ? 16'h2000 : 16'h4000));
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   sequence s_fault;
      flt;
   endsequence
   sequence s_take;
      FAST_INTERRUPT_REQUEST && FAST_IRQ_TAKEN && !flt;
   endsequence
   a_prog_int_route: assert property (p_hi |=> PROG_INT_SEL && !PROG_CACHE_SEL
      && PROG_INT_ADDR == $past(PROG_REQ.addr[12:0])) else $error("fetch not internal");
   a_prog_cache_route: assert property (PROG_REQ.valid && !p_hi |=> PROG_CACHE_SEL
      && !PROG_INT_SEL) else $error("fetch not to cache");
   a_prog_ext_form: assert property (
      PROG_REQ.valid && !p_hi && INSTR_CACHE_BASE_POINTER[23] |=> PROG_EXT_REQ ==
      {2'h3, $past(INSTR_CACHE_BASE_POINTER[23:18]), $past(PROG_REQ.addr[17:0])})
      else $error("external fetch address wrong");
   a_data_int_route: assert property (
      DATA_REQ.valid && DATA_REQ.addr inside {[22'h200000:22'h211FFF]} |=> DATA_INT_SEL)
      else $error("data not internal");
   a_cop_x_route: assert property (
      COP_REQ.valid && !COP_REQ.ymem && COP_REQ.addr < 16'h4000 |=> COP_X_SEL)
      else $error("coprocessor X not selected");
   a_irq_raise: assert property (s_fault |=> FAST_INTERRUPT_REQUEST)
      else $error("violation not raised");
   a_irq_gated: assert property (!FAST_INTERRUPT_REQUEST && !flt |=>
      !FAST_INTERRUPT_REQUEST) else $error("request without enabled violation");
   a_irq_hold: assert property (FAST_INTERRUPT_REQUEST && !FAST_IRQ_TAKEN |=>
      FAST_INTERRUPT_REQUEST) else $error("request dropped before take");
   a_irq_release: assert property (s_take |=> !FAST_INTERRUPT_REQUEST)
      else $error("request held after take");
endmodule : cmad_decoder_checker

bind cmad_decoder cmad_decoder_checker i_checker (.CLK(CLK), .RST_N(RST_N),
   .PROG_REQ(PROG_REQ), .DATA_REQ(DATA_REQ), .COP_REQ(COP_REQ),
   .FAST_IRQ_ENABLE_BIT(FAST_IRQ_ENABLE_BIT), .FAST_IRQ_TAKEN(FAST_IRQ_TAKEN),
   .INSTR_CACHE_BASE_POINTER(INSTR_CACHE_BASE_POINTER), .PROG_INT_SEL(PROG_INT_SEL),
   .PROG_CACHE_SEL(PROG_CACHE_SEL), .PROG_INT_ADDR(PROG_INT_ADDR),
   .DATA_INT_SEL(DATA_INT_SEL), .COP_X_SEL(COP_X_SEL), .PROG_EXT_REQ(PROG_EXT_REQ),
   .FAST_INTERRUPT_REQUEST(FAST_INTERRUPT_REQUEST));

//--- testbench/cmad_core_model.sv
// Host core side: takes the fast interrupt promptly or after a delay
`timescale 1ns/10ps
module cmad_core_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Interrupt handshake
   input wire logic irq_req,
   input wire logic slow,
   output logic taken
);
   logic [2:0] cnt;
   // Falling edge so the decoder samples a settled take
   always_ff @(negedge clk or negedge rst_n) begin
      if (!rst_n || taken || !irq_req) begin
         taken <= 1'b0;
         cnt <= 3'h0;
      end else if (cnt >= (slow ? 3'h5 : 3'h0)) begin
         taken <= 1'b1;
      end else begin
         cnt <= cnt + 3'h1;
      end
   end
endmodule : cmad_core_model

//--- testbench/testbench.sv
// Self-checking bench for the core memory address decoder
`timescale 1ns/10ps
module testbench;
   logic CLK, RST_N, en, tk, slow, pi, pc, di, dc, cx, cy, irq, exp_irq;
   cmad_pkg::cmad_prog_req_t pr;
   cmad_pkg::cmad_data_req_t dr;
   cmad_pkg::cmad_cop_req_t cr;
   cmad_pkg::cmad_ext_req_t pe, de;
   logic [23:0] ib, dbp;
   logic [1:0] ss;
   logic [12:0] pa;
   logic [16:0] da;
   logic [13:0] ca;
   logic [31:0] seed = 32'h0000004F;
   int num_errors = 0;
   int samples_checked = 0;
   cmad_decoder i_cmad_decoder (.CLK(CLK), .RST_N(RST_N), .PROG_REQ(pr), .DATA_REQ(dr),
      .COP_REQ(cr), .FAST_IRQ_ENABLE_BIT(en), .FAST_IRQ_TAKEN(tk),
      .INSTR_CACHE_BASE_POINTER(ib), .DATA_CACHE_BASE_POINTER(dbp), .SRAM_SIZE_SEL(ss),
      .PROG_INT_SEL(pi), .PROG_CACHE_SEL(pc), .PROG_INT_ADDR(pa), .DATA_INT_SEL(di),
      .DATA_CACHE_SEL(dc), .DATA_INT_ADDR(da), .COP_X_SEL(cx), .COP_Y_SEL(cy),
      .COP_INT_ADDR(ca), .PROG_EXT_REQ(pe), .DATA_EXT_REQ(de), .FAST_INTERRUPT_REQUEST(irq));
   cmad_core_model i_cmad_core_model (.clk(CLK), .rst_n(RST_N), .irq_req(irq), .slow(slow),
      .taken(tk));
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   function automatic logic [25:0] ext_exp(input logic [23:0] b, input logic [17:0] o,
         input logic [1:0] s);
      logic [23:0] a;
      a = {b[23:18], o};
      if (!b[23]) a = a & ((24'h040000 << s) - 24'h000001);
      return {1'b1, b[23], a};
   endfunction : ext_exp
   task automatic chk(input string n, input logic [25:0] s, input logic [25:0] e);
      samples_checked++;
      if (s !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic step(input logic [21:0] p, input logic [22:0] d, input logic [17:0] c,
         input logic e);
      logic t, ok_c, bad_d;
      @(negedge CLK);
      {pr, dr, cr, en} = {p, d, c, e};
      ib = 24'(rnd());
      dbp = 24'(rnd());
      ss = 2'(rnd());
      @(posedge CLK);
      t = tk;
      #1;
      bad_d = dr.valid && dr.addr >= 22'h212000;
      ok_c = cr.valid && cr.addr < (cr.ymem ? 16'h2000 : 16'h4000);
      exp_irq = (bad_d || cr.valid && !ok_c) && en || exp_irq && !t;
      chk("data_int", di, dr.valid && dr.addr[21] && !bad_d);
      chk("data_cache", dc, dr.valid && !dr.addr[21]);
      if (di) chk("data_addr", da, dr.addr[16:0]);
      if (dc) chk("data_ext", de, ext_exp(dbp, dr.addr[17:0], ss));
      chk("prog_int", pi, pr.valid && ({pr.addr, 1'b0} > 22'h3FBFFF));
      chk("prog_cache", pc, pr.valid && ({pr.addr, 1'b0} < 22'h3FC000));
      if (pi) chk("prog_addr", pa, pr.addr[12:0]);
      if (pc) chk("prog_ext", pe, ext_exp(ib, pr.addr[17:0], ss));
      chk("cop_sel", {cy, cx}, {cr.ymem, !cr.ymem} & {2{ok_c}});
      if (ok_c) chk("cop_addr", ca, cr.addr[13:0]);
      chk("irq", irq, exp_irq);
   endtask : step
   task automatic results();
      $display("checked %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : results
   initial begin
      CLK = 1'b0;
      forever #4 CLK = ~CLK;
   end
   initial begin
      #100000;
      num_errors++;
      results();
   end
   initial begin
      logic [31:0] r, q;
      {pr, dr, cr, en, ib, dbp, ss, slow, exp_irq} = '0;
      RST_N = 1'b0;
      repeat (5) @(posedge CLK);
      @(negedge CLK);
      RST_N = 1'b1;
      step(22'h3FDFFF, 23'h611FFF, 18'h23FFF, 1'b1);
      step(22'h3FE000, 23'h612000, 18'h31FFF, 1'b1);
      step(22'h3FFFFF, 23'h400000, 18'h24000, 1'b1);
      step(22'h200000, 23'h7FFFFF, 18'h3C000, 1'b0);
      for (int i = 0; i < 3000; i++) begin
         slow = i[8];
         r = rnd();
         q = rnd();
         step({r[0], r[1] ? {8'hFF, r[14:2]} : r[22:2]}, {r[23], r[24],
            r[25] ? {4'h0, q[16:0]} : q[20:0]}, {q[31], q[30],
            q[29] ? {2'h0, q[13:0]} : q[15:0]}, r[31] | r[30]);
      end
      slow = 1'b1;
      step(22'h0, 23'h612000, 18'h0, 1'b1);
      RST_N = 1'b0;
      {pr, dr, cr} = '0;
      @(negedge CLK);
      chk("irq_reset", irq, 1'b0);
      @(negedge CLK);
      RST_N = 1'b1;
      exp_irq = 1'b0;
      step(22'h3FE000, 23'h611FFF, 18'h31FFF, 1'b1);
      results();
   end
endmodule : testbench
